// ---- rtl/swdt_defs.svh ----
// Constants for the super I/O watchdog: keys, indices, fields, timing
`ifndef SWDT_DEFS_SVH
`define SWDT_DEFS_SVH
`define SWDT_KEY_UNLOCK 8'h87
`define SWDT_KEY_LOCK 8'haa
`define SWDT_IDX_LDSEL 8'h07
`define SWDT_IDX_ACT 8'h30
`define SWDT_IDX_UNIT 8'hf5
`define SWDT_IDX_COUNT 8'hf6
`define SWDT_IDX_CTRL 8'hf7
`define SWDT_LDN_WDT 8'h08
`define SWDT_ACT_ON 8'h01
`define SWDT_UNIT_MIN_BIT 3
`define SWDT_UNIT_FAST_BIT 4
`define SWDT_CTRL_MS_BIT 7
`define SWDT_CTRL_KB_BIT 6
`define SWDT_CTRL_FORCE_BIT 5
`define SWDT_CTRL_STAT_BIT 4
`define SWDT_COUNT_RESET 8'h00
`define SWDT_CLK_HZ 125000000
`define SWDT_FAST_DIV 1000
`define SWDT_MIN_SECONDS 60
`define SWDT_MS_CYCLES (`SWDT_CLK_HZ / `SWDT_FAST_DIV)
`define SWDT_RST_PULSE_CYCLES 16
`endif

// ---- rtl/swdt_pkg.sv ----
// Types shared by the watchdog block
package swdt_pkg;
    typedef enum logic [2:0] {
        SWDT_LOCKED = 3'b001,
        SWDT_HALF = 3'b010,
        SWDT_OPEN = 3'b100
    } swdt_cfg_t;
endpackage : swdt_pkg

// ---- rtl/swdt_tick.sv ----
// Unit tick generator: one pulse per second, minute or thousandth of them
`timescale 1ns/100ps
`include "swdt_defs.svh"
module swdt_tick
#(
    parameter int MS_CYCLES = `SWDT_MS_CYCLES
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Control
    input wire logic restart_i,
    input wire logic minutes_i,
    input wire logic fast_i,
    // Tick out
    output logic tick_o
);
    logic [31:0] cyc;
    logic [9:0] ms;
    logic [5:0] sec;
    logic ms_end;
    logic sec_end;
    logic min_end;
    logic [5:0] fm;
    logic fm_end;

    assign ms_end = (cyc == 32'(MS_CYCLES - 1));
    assign sec_end = ms_end && (ms == 10'(`SWDT_FAST_DIV - 1));
    assign min_end = sec_end && (sec == 6'(`SWDT_MIN_SECONDS - 1));
    assign fm_end = ms_end && (fm == 6'(`SWDT_MIN_SECONDS - 1));

    always_ff @(posedge clk_i)
    begin
        if (srst_i || restart_i || ms_end)
            cyc <= 32'h0;
        else
            cyc <= cyc + 32'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i || restart_i || sec_end)
            ms <= 10'h0;
        else if (ms_end)
            ms <= ms + 10'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i || restart_i || min_end)
            sec <= 6'h0;
        else if (sec_end)
            sec <= sec + 6'h1;
    end

    // Own count of sixty ms, so the period stays even across a second
    always_ff @(posedge clk_i)
    begin
        if (srst_i || restart_i || fm_end)
            fm <= 6'h0;
        else if (ms_end)
            fm <= fm + 6'h1;
    end

    // Fast mode: seconds become ms, minutes become sixty ms
    always_ff @(posedge clk_i)
    begin
        if (srst_i || restart_i)
            tick_o <= 1'b0;
        else if (fast_i && minutes_i)
            tick_o <= fm_end;
        else if (fast_i)
            tick_o <= ms_end;
        else if (minutes_i)
            tick_o <= min_end;
        else
            tick_o <= sec_end;
    end
endmodule : swdt_tick

// ---- rtl/swdt_port.sv ----
// Index/data port decoder with the unlock key sequence
`timescale 1ns/100ps
`include "swdt_defs.svh"
module swdt_port
    import swdt_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Host index port write
    input wire logic idx_wr_i,
    input wire logic [7:0] wdata_i,
    // Session state
    output logic open_o,
    output logic [7:0] index_o
);
    swdt_cfg_t state;

    // Two back-to-back unlock keys open, lock key closes
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            state <= SWDT_LOCKED;
        else if (idx_wr_i)
        begin
            case (state)
                SWDT_LOCKED:
                    if (wdata_i == `SWDT_KEY_UNLOCK)
                        state <= SWDT_HALF;
                SWDT_HALF:
                    if (wdata_i == `SWDT_KEY_UNLOCK)
                        state <= SWDT_OPEN;
                    else
                        state <= SWDT_LOCKED;
                SWDT_OPEN:
                    if (wdata_i == `SWDT_KEY_LOCK)
                        state <= SWDT_LOCKED;
                default:
                    state <= SWDT_LOCKED;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            index_o <= 8'h00;
        else if (idx_wr_i && state == SWDT_OPEN)
            index_o <= wdata_i;
    end

    assign open_o = (state == SWDT_OPEN);
endmodule : swdt_port

// ---- rtl/swdt_top.sv ----
// Super I/O watchdog: configuration ports, registers, countdown, reset
`timescale 1ns/100ps
`include "swdt_defs.svh"

module swdt_top
    import swdt_pkg::*;
#(
    parameter int MS_CYCLES = `SWDT_MS_CYCLES,
    parameter int RST_CYCLES = `SWDT_RST_PULSE_CYCLES
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Host I/O cycles
    input wire logic idx_wr_i,
    input wire logic data_wr_i,
    input wire logic data_rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // Activity strobes
    input wire logic kbd_act_i,
    input wire logic mouse_act_i,
    // Watchdog outputs
    output logic timeout_o,
    output logic sys_rst_o
);
    // ========================================
    // Port decoder
    logic open;
    logic [7:0] index;
    logic [7:0] ldn;
    logic active;
    logic [7:0] unit;
    logic [7:0] count_reg;
    logic kb_en;
    logic ms_en;
    logic status;
    logic [7:0] remain;
    logic tick;
    logic wdt_sel;
    logic wr_ok;
    logic count_wr;
    logic force_wr;
    logic reload;
    logic expire;
    logic [7:0] pulse;

    swdt_port swdt_port_i (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .idx_wr_i(idx_wr_i),
        .wdata_i(wdata_i),
        .open_o(open),
        .index_o(index)
    );

    assign wdt_sel = (ldn == `SWDT_LDN_WDT);
    assign wr_ok = data_wr_i && open && wdt_sel;
    assign count_wr = wr_ok && index == `SWDT_IDX_COUNT;
    assign force_wr = wr_ok && index == `SWDT_IDX_CTRL
        && wdata_i[`SWDT_CTRL_FORCE_BIT];

    // ========================================
    // Configuration registers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            ldn <= 8'h00;
        else if (data_wr_i && open && index == `SWDT_IDX_LDSEL)
            ldn <= wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            active <= 1'b0;
        else if (wr_ok && index == `SWDT_IDX_ACT)
            active <= wdata_i[0];
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            unit <= 8'h00;
        else if (wr_ok && index == `SWDT_IDX_UNIT)
            unit <= wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            count_reg <= `SWDT_COUNT_RESET;
        else if (count_wr)
            count_reg <= wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            kb_en <= 1'b0;
            ms_en <= 1'b0;
        end
        else if (wr_ok && index == `SWDT_IDX_CTRL)
        begin
            kb_en <= wdata_i[`SWDT_CTRL_KB_BIT];
            ms_en <= wdata_i[`SWDT_CTRL_MS_BIT];
        end
    end

    // ========================================
    // Countdown
    swdt_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) swdt_tick_i (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .restart_i(reload),
        .minutes_i(unit[`SWDT_UNIT_MIN_BIT]),
        .fast_i(unit[`SWDT_UNIT_FAST_BIT]),
        .tick_o(tick)
    );

    assign reload = count_wr || (kb_en && kbd_act_i)
        || (ms_en && mouse_act_i);
    assign expire = active && remain == 8'h01 && tick && !reload;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            remain <= 8'h00;
        else if (count_wr)
            remain <= wdata_i;
        else if (reload)
            remain <= count_reg;
        else if (active && tick && remain != 8'h00)
            remain <= remain - 8'h01;
    end

    // Status sets on expiry or forced timeout; set wins over a clear
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            status <= 1'b0;
        else if (expire || force_wr)
            status <= 1'b1;
        else if (wr_ok && index == `SWDT_IDX_CTRL
            && !wdata_i[`SWDT_CTRL_STAT_BIT])
            status <= 1'b0;
    end

    // ========================================
    // Outputs
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            timeout_o <= 1'b0;
        else
            timeout_o <= expire || force_wr;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            pulse <= 8'h00;
        else if (expire || force_wr)
            pulse <= 8'(RST_CYCLES);
        else if (pulse != 8'h00)
            pulse <= pulse - 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            sys_rst_o <= 1'b0;
        else
            sys_rst_o <= (expire || force_wr) || pulse > 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rdata_o <= 8'h00;
        else if (data_rd_i && open)
        begin
            case (index)
                `SWDT_IDX_LDSEL: rdata_o <= ldn;
                `SWDT_IDX_ACT: rdata_o <= {7'h00, active};
                `SWDT_IDX_UNIT: rdata_o <= unit;
                `SWDT_IDX_COUNT: rdata_o <= wdt_sel ? remain : 8'h00;
                `SWDT_IDX_CTRL: rdata_o <= wdt_sel ?
                    {ms_en, kb_en, 1'b0, status, 4'h0} : 8'h00;
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    // ========================================
    // Checks
    // Host access and session
    a_open_rise: assert property (
        @(posedge clk_i) disable iff (srst_i)
        $rose(open)
        |-> $past(idx_wr_i) && $past(wdata_i) == `SWDT_KEY_UNLOCK)
        else $error("opened without unlock key");

    a_index_load: assert property (
        @(posedge clk_i) disable iff (srst_i)
        open && idx_wr_i |=> index == $past(wdata_i))
        else $error("index not taken");

    a_lock_key: assert property (
        @(posedge clk_i) disable iff (srst_i)
        open && idx_wr_i && wdata_i == `SWDT_KEY_LOCK |=> !open)
        else $error("lock key ignored");

    a_ldn_load: assert property (
        @(posedge clk_i) disable iff (srst_i)
        data_wr_i && open && index == `SWDT_IDX_LDSEL
        |=> ldn == $past(wdata_i))
        else $error("select write lost");

    a_wdt_gate: assert property (
        @(posedge clk_i) disable iff (srst_i)
        data_wr_i && !wdt_sel |=> $stable(count_reg))
        else $error("count changed while not selected");

    a_locked_no_write: assert property (
        @(posedge clk_i) disable iff (srst_i)
        data_wr_i && !open |=> $stable(count_reg))
        else $error("count changed while locked");

    // Registers and countdown
    a_activate: assert property (
        @(posedge clk_i) disable iff (srst_i)
        wr_ok && index == `SWDT_IDX_ACT |=> active == $past(wdata_i[0]))
        else $error("enable write lost");

    a_disabled_quiet: assert property (
        @(posedge clk_i) disable iff (srst_i)
        !active && !force_wr |=> !timeout_o)
        else $error("timeout while disabled");

    a_unit_load: assert property (
        @(posedge clk_i) disable iff (srst_i)
        wr_ok && index == `SWDT_IDX_UNIT |=> unit == $past(wdata_i))
        else $error("unit write lost");

    a_count_restart: assert property (
        @(posedge clk_i) disable iff (srst_i)
        count_wr |=> remain == $past(wdata_i))
        else $error("count write did not restart");

    a_zero_stops: assert property (
        @(posedge clk_i) disable iff (srst_i)
        remain == 8'h00 && !count_wr && !reload |=> remain == 8'h00)
        else $error("stopped timer moved");

    a_tick_dec: assert property (
        @(posedge clk_i) disable iff (srst_i)
        active && tick && !reload && remain > 8'h01
        |=> remain == $past(remain) - 8'h01)
        else $error("countdown skipped");

    a_last_unit: assert property (
        @(posedge clk_i) disable iff (srst_i)
        active && tick && !reload && remain == 8'h01 |=> timeout_o)
        else $error("last unit gave no timeout");

    a_ctrl_load: assert property (
        @(posedge clk_i) disable iff (srst_i)
        wr_ok && index == `SWDT_IDX_CTRL
        |=> kb_en == $past(wdata_i[`SWDT_CTRL_KB_BIT])
        && ms_en == $past(wdata_i[`SWDT_CTRL_MS_BIT]))
        else $error("strobe enables not taken");

    a_kb_reload: assert property (
        @(posedge clk_i) disable iff (srst_i)
        kb_en && kbd_act_i && !count_wr |=> remain == $past(count_reg))
        else $error("keyboard reload failed");

    a_ms_reload: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ms_en && mouse_act_i && !count_wr |=> remain == $past(count_reg))
        else $error("mouse reload failed");

    // Timeout and reset
    a_force_timeout: assert property (
        @(posedge clk_i) disable iff (srst_i)
        force_wr |=> timeout_o && status)
        else $error("forced timeout missing");

    a_expire_status: assert property (
        @(posedge clk_i) disable iff (srst_i)
        expire |=> status && timeout_o)
        else $error("expiry not flagged");

    a_expire_reset: assert property (
        @(posedge clk_i) disable iff (srst_i)
        expire |=> sys_rst_o ##1 sys_rst_o)
        else $error("system reset not held");
endmodule : swdt_top

// ---- verification/swdt_host.sv ----
// Host processor model issuing index and data port cycles
`timescale 1ns/100ps
module swdt_host
(
    // Clock
    input wire logic clk_i,
    // Port cycles
    output logic idx_wr_o,
    output logic data_wr_o,
    output logic data_rd_o,
    output logic [7:0] wdata_o
);
    // ==========================================
    // Port cycles
    initial
    begin
        idx_wr_o = 1'b0;
        data_wr_o = 1'b0;
        data_rd_o = 1'b0;
        wdata_o = 8'h5a;
    end
    // Kind 0 index write, 1 data write, 2 data read
    task cyc(input logic [1:0] kind, input logic [7:0] d);
        @(negedge clk_i);
        idx_wr_o = (kind == 2'h0);
        data_wr_o = (kind == 2'h1);
        data_rd_o = (kind == 2'h2);
        wdata_o = d;
        @(negedge clk_i);
        idx_wr_o = 1'b0;
        data_wr_o = 1'b0;
        data_rd_o = 1'b0;
        // Released bus shows no stale byte
        wdata_o = ~d;
    endtask : cyc
    task unlock;
        cyc(2'h0, 8'h87);
        cyc(2'h0, 8'h87);
    endtask : unlock
    task lock;
        cyc(2'h0, 8'haa);
    endtask : lock
    task wreg(input logic [7:0] idx, input logic [7:0] val);
        cyc(2'h0, idx);
        cyc(2'h1, val);
    endtask : wreg
    task rreg(input logic [7:0] idx);
        cyc(2'h0, idx);
        cyc(2'h2, 8'h00);
    endtask : rreg
endmodule : swdt_host

// ---- verification/superio_watchdog_timer_test.sv ----
// Self-checking bench for the super I/O watchdog
`timescale 1ns/100ps
module superio_watchdog_timer_test;
    localparam int RST = 5;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic idx_wr_i;
    logic data_wr_i;
    logic data_rd_i;
    logic [7:0] wdata_i;
    logic [7:0] rdata_o;
    logic kbd_act_i = 1'b0;
    logic mouse_act_i = 1'b0;
    logic timeout_o;
    logic sys_rst_o;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int v;
    always #4 clk_i = ~clk_i;
    swdt_top #(.MS_CYCLES(2), .RST_CYCLES(RST)) swdt_top_i (
        .clk_i(clk_i), .srst_i(srst_i), .idx_wr_i(idx_wr_i),
        .data_wr_i(data_wr_i), .data_rd_i(data_rd_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .kbd_act_i(kbd_act_i),
        .mouse_act_i(mouse_act_i), .timeout_o(timeout_o),
        .sys_rst_o(sys_rst_o));
    swdt_host swdt_host_i (
        .clk_i(clk_i), .idx_wr_o(idx_wr_i), .data_wr_o(data_wr_i),
        .data_rd_o(data_rd_i), .wdata_o(wdata_i));
    // ==========================================
    // Checking and reporting
    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end
    // Read data lands the cycle after the strobe
    always @(posedge clk_i)
        rd_seen <= data_rd_i;
    always @(negedge clk_i)
        if (rd_seen && exp_q.size() > 0)
            check(rdata_o, exp_q.pop_front());
    // ==========================================
    // Stimulus helpers
    task wr(input logic [7:0] idx, input logic [7:0] val);
        swdt_host_i.wreg(idx, val);
    endtask : wr
    task rd(input logic [7:0] idx, input logic [7:0] exp);
        exp_q.push_back(exp);
        swdt_host_i.rreg(idx);
    endtask : rd
    task wait_to(input int e);
        int n;
        logic ok;
        n = 0;
        while (timeout_o !== 1'b1 && n <= e + 3)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        ok = (n >= e - 2) && (n <= e + 3);
        check({7'h0, ok}, 8'h01);
    endtask : wait_to
    task quiet(input int c);
        logic seen;
        seen = 1'b0;
        repeat (c)
        begin
            @(posedge clk_i);
            #1;
            seen = seen | timeout_o;
        end
        check({7'h0, seen}, 8'h00);
    endtask : quiet
    task done(input string s);
        $display("test %s done", s);
    endtask : done
    // ==========================================
    // Main sequence
    initial
    begin
        v = $urandom(96269);
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        srst_i = 1'b0;
        wr(8'hf6, 8'h05);
        swdt_host_i.cyc(2'h0, 8'h87);
        swdt_host_i.cyc(2'h0, 8'h12);
        swdt_host_i.cyc(2'h0, 8'h87);
        wr(8'h07, 8'h08);
        rd(8'hf6, 8'h00);
        swdt_host_i.unlock();
        wr(8'hf6, 8'h33);
        wr(8'h07, 8'h08);
        rd(8'hf6, 8'h00);
        rd(8'hf7, 8'h00);
        rd(8'h55, 8'h00);
        done("access");
        repeat (4)
        begin
            v = $urandom_range(255, 1);
            wr(8'hf6, v[7:0]);
            rd(8'hf6, v[7:0]);
        end
        wr(8'hf5, 8'h10);
        wr(8'hf6, 8'h03);
        quiet(40);
        wr(8'h30, 8'h01);
        wr(8'hf6, 8'h03);
        wait_to(6);
        rd(8'hf7, 8'h10);
        wr(8'hf7, 8'h00);
        rd(8'hf7, 8'h00);
        wr(8'hf6, 8'h00);
        quiet(60);
        wr(8'hf6, 8'h08);
        repeat (10) @(negedge clk_i);
        wr(8'hf6, 8'h04);
        wait_to(8);
        wr(8'hf5, 8'h18);
        wr(8'hf6, 8'h02);
        wait_to(240);
        wr(8'hf5, 8'h00);
        wr(8'hf6, 8'h02);
        wait_to(4000);
        done("count");
        wr(8'hf5, 8'h10);
        for (int s = 0; s < 2; s++)
        begin
            wr(8'hf7, s ? 8'h40 : 8'h80);
            {mouse_act_i, kbd_act_i} = s ? 2'b10 : 2'b01;
            wr(8'hf6, 8'h05);
            wait_to(10);
            wr(8'hf7, s ? 8'h80 : 8'h40);
            wr(8'hf6, 8'h05);
            quiet(40);
            @(negedge clk_i);
            {mouse_act_i, kbd_act_i} = 2'b00;
            wait_to(10);
        end
        done("strobes");
        repeat (10) @(negedge clk_i);
        wr(8'hf7, 8'h20);
        wait_to(0);
        v = 0;
        while (sys_rst_o === 1'b1 && v < 40)
        begin
            @(posedge clk_i);
            #1;
            v++;
        end
        check(v[7:0], 8'(RST));
        rd(8'hf7, 8'h10);
        done("force");
        swdt_host_i.lock();
        wr(8'hf6, 8'h07);
        rd(8'hf6, 8'h10);
        swdt_host_i.unlock();
        wr(8'h07, 8'h08);
        rd(8'hf6, 8'h00);
        done("lock");
        final_report();
    end
endmodule : superio_watchdog_timer_test
